// *** rtl/frc_top.sv ***
// Decided for this implementation: the address map and the Avalon-MM register port.
`timescale 1ns/1ns

// Contract
// - Write width from the write width select alone
// - Read width from the read width select alone
// - Reset samples strobe, selects: default offsets
// - Reset strobe level picks serial or parallel
// - Strobe low redirects accesses to offsets
// - Mark records present read pointer
// - Retransmit returns read pointer to mark
// - Master reset zeroes pointers and output
// - Master reset latches all configuration
// - Output enable controls data three-state
// - Only output enable floats outputs in reset
// - Almost-empty high when count reaches n
// - Almost-full high while free exceeds m
// - Flag timing select latched, high is synchronous
// - Flag selects sampled only during master reset
// - Serial clock edge shifts serial bit in
module frc_top
  import frc_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire frc_strap_t strap_i,
  input wire logic master_reset_n_i,
  input wire logic partial_reset_n_i,
  input wire logic output_enable_n_i,
  input wire logic serial_offset_clk_i,
  input wire logic serial_offset_enable_n_i,
  input wire logic offset_access_strobe_n_i,
  input wire logic mark_i,
  input wire logic retransmit_i,
  input wire logic wr_en_i,
  input wire logic [FRC_DW-1:0] wr_data_i,
  input wire logic rd_en_i,
  output logic [FRC_DW-1:0] q_o,
  output logic q_oe_n_o,
  output logic almost_empty_flag_o,
  output logic almost_full_flag_o,
  input wire logic [4:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic irq_o
);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // Returns {write_narrow, read_narrow} for a width select pair
  function automatic logic [1:0] frc_port_widths(input logic iw, input logic ow);
    logic [1:0] r;
    r = 2'h0;
    case ({iw, ow})
      2'b00: r = 2'b00;
      2'b01: r = 2'b01;
      2'b10: r = 2'b10;
      2'b11: r = 2'b11;
      default: r = 2'b00;
    endcase
    return r;
  endfunction : frc_port_widths

  function automatic logic [FRC_DW-1:0] frc_mask(input logic narrow);
    return narrow ? FRC_MASK_NARROW : FRC_MASK_WIDE;
  endfunction : frc_mask

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  localparam int SYNC_W = $bits(frc_strap_t) + 5;
  logic [SYNC_W-1:0] sync1;
  logic [SYNC_W-1:0] sync2;
  frc_strap_t s_strap;
  logic s_mrs_n;
  logic s_prs_n;
  logic s_oe_n;
  logic s_sclk;
  logic s_sen_n;
  logic sclk_d;

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      sync1 <= '0;
      sync2 <= '0;
      sclk_d <= 1'b0;
    end else begin
      sync1 <= {strap_i, master_reset_n_i, partial_reset_n_i, output_enable_n_i,
                serial_offset_clk_i, serial_offset_enable_n_i};
      sync2 <= sync1;
      sclk_d <= s_sclk;
    end
  end

  assign {s_strap, s_mrs_n, s_prs_n, s_oe_n, s_sclk, s_sen_n} = sync2;

  // ----------------------------------------------------------------
  // Configuration latched at master reset
  // ----------------------------------------------------------------
  frc_cfg_t cfg;
  frc_ofs_t ofs;
  frc_ofs_sel_t ofs_sel;
  logic [2:0] def_idx;
  logic [1:0] widths;
  logic soft_prs;
  logic ptr_clr;

  assign def_idx = {offset_access_strobe_n_i, s_strap.default_offset_sel_hi,
                    s_strap.default_offset_sel_lo};
  assign widths = frc_port_widths(s_strap.write_width_select, s_strap.read_width_select);
  assign ptr_clr = !s_mrs_n || !s_prs_n || soft_prs;

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      cfg <= FRC_CFG_RST;
    end else if (!s_mrs_n) begin
      cfg.fall_through <= s_strap.fall_through_mode;
      cfg.write_narrow <= widths[1];
      cfg.read_narrow <= widths[0];
      cfg.async_write <= !s_strap.async_write_sel;
      cfg.async_read <= !s_strap.async_read_sel;
      cfg.byte_order <= s_strap.byte_order_sel;
      cfg.zero_latency <= s_strap.zero_latency_sel;
      cfg.parity <= s_strap.parity_sel;
      cfg.flag_sync <= s_strap.flag_timing_select;
      cfg.serial_prog <= !offset_access_strobe_n_i;
      cfg.ofs_idx <= def_idx;
    end
  end

  // ----------------------------------------------------------------
  // Offset registers
  // ----------------------------------------------------------------
  logic ofs_acc;
  logic sclk_rise;

  assign ofs_acc = !offset_access_strobe_n_i && s_mrs_n;
  assign sclk_rise = s_sclk && !sclk_d;

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      ofs <= FRC_DEF_OFS[0];
    end else if (!s_mrs_n) begin
      ofs <= FRC_DEF_OFS[def_idx];
    end else if (cfg.serial_prog && !s_sen_n && sclk_rise) begin
      // Serial data shares the fall-through strap pin after reset
      ofs <= {ofs[2*FRC_CW-2:0], s_strap.fall_through_mode};
    end else if (!cfg.serial_prog && ofs_acc && wr_en_i) begin
      if (ofs_sel == FRC_OFS_EMPTY) begin
        ofs.empty_ofs <= wr_data_i[FRC_CW-1:0];
      end else begin
        ofs.full_ofs <= wr_data_i[FRC_CW-1:0];
      end
    end
  end

  // Empty then full, for both loading and readback
  always_ff @(posedge mclk_i) begin
    if (rst_i || !s_mrs_n || !ofs_acc) begin
      ofs_sel <= FRC_OFS_EMPTY;
    end else if (wr_en_i || rd_en_i) begin
      case (ofs_sel)
        FRC_OFS_EMPTY: ofs_sel <= FRC_OFS_FULL;
        FRC_OFS_FULL: ofs_sel <= FRC_OFS_EMPTY;
        default: ofs_sel <= FRC_OFS_EMPTY;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Pointers, mark and memory
  // ----------------------------------------------------------------
  logic [FRC_DW-1:0] mem [FRC_DEPTH];
  logic [FRC_CW-1:0] wr_ptr;
  logic [FRC_CW-1:0] rd_ptr;
  logic [FRC_CW-1:0] mark_ptr;
  logic mark_valid;
  logic [FRC_CW-1:0] count;
  logic [FRC_CW-1:0] free;
  logic fifo_empty;
  logic fifo_full;
  logic wr_ok;
  logic rd_ok;

  assign count = wr_ptr - rd_ptr;
  assign free = FRC_DEPTH_CNT - count;
  assign fifo_empty = (count == '0);
  assign fifo_full = (count == FRC_DEPTH_CNT);
  // Memory moves only with the strobe high
  assign wr_ok = wr_en_i && !ofs_acc && !fifo_full && !ptr_clr;
  assign rd_ok = rd_en_i && !ofs_acc && !fifo_empty && !ptr_clr;

  always_ff @(posedge mclk_i) begin
    if (rst_i || ptr_clr) begin
      wr_ptr <= '0;
    end else if (wr_ok) begin
      wr_ptr <= wr_ptr + 7'h01;
    end
  end

  // Retransmit wins over a read in the same cycle
  always_ff @(posedge mclk_i) begin
    if (rst_i || ptr_clr) begin
      rd_ptr <= '0;
    end else if (retransmit_i) begin
      rd_ptr <= mark_valid ? mark_ptr : '0;
    end else if (rd_ok) begin
      rd_ptr <= rd_ptr + 7'h01;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i || ptr_clr) begin
      mark_ptr <= '0;
      mark_valid <= 1'b0;
    end else if (mark_i) begin
      mark_ptr <= rd_ptr;
      mark_valid <= 1'b1;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (wr_ok) begin
      mem[wr_ptr[FRC_CW-2:0]] <= wr_data_i & frc_mask(cfg.write_narrow);
    end
  end

  // ----------------------------------------------------------------
  // Output register and three-state control
  // ----------------------------------------------------------------
  logic [FRC_DW-1:0] head;

  assign head = mem[rd_ptr[FRC_CW-2:0]] & frc_mask(cfg.read_narrow);

  always_ff @(posedge mclk_i) begin
    if (rst_i || ptr_clr) begin
      q_o <= '0;
    end else if (ofs_acc && rd_en_i) begin
      q_o <= (ofs_sel == FRC_OFS_EMPTY) ? {11'h000, ofs.empty_ofs} : {11'h000, ofs.full_ofs};
    end else if (cfg.fall_through ? !fifo_empty : rd_ok) begin
      q_o <= head;
    end
  end

  // Registered, so a change lags the pin by the synchroniser plus one edge
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      q_oe_n_o <= 1'b1;
    end else begin
      q_oe_n_o <= s_oe_n;
    end
  end

  // ----------------------------------------------------------------
  // Programmable flags
  // ----------------------------------------------------------------
  logic ae_now;
  logic af_now;
  logic ae_stage;
  logic af_stage;

  assign ae_now = (count >= ofs.empty_ofs);
  assign af_now = (free > ofs.full_ofs);

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      ae_stage <= 1'b0;
      af_stage <= 1'b1;
      almost_empty_flag_o <= 1'b0;
      almost_full_flag_o <= 1'b1;
    end else begin
      ae_stage <= ae_now;
      af_stage <= af_now;
      // Synchronous timing adds one edge
      almost_empty_flag_o <= cfg.flag_sync ? ae_stage : ae_now;
      almost_full_flag_o <= cfg.flag_sync ? af_stage : af_now;
    end
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  logic [FRC_IRQ_W-1:0] irq_status;
  logic [FRC_IRQ_W-1:0] irq_mask;
  logic [FRC_IRQ_W-1:0] irq_event;
  logic [FRC_IRQ_W-1:0] irq_clr;
  logic ae_prev;
  logic af_prev;

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      ae_prev <= 1'b0;
      af_prev <= 1'b1;
    end else begin
      ae_prev <= ae_now;
      af_prev <= af_now;
    end
  end

  always_comb begin
    irq_event = '0;
    irq_event[FRC_IRQ_AE_RISE] = ae_now && !ae_prev;
    irq_event[FRC_IRQ_AF_FALL] = !af_now && af_prev;
    irq_event[FRC_IRQ_OVERFLOW] = wr_en_i && !ofs_acc && fifo_full;
    irq_event[FRC_IRQ_UNDERFLOW] = rd_en_i && !ofs_acc && fifo_empty;
  end

  // A new event beats a clear in the same cycle
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      irq_status <= FRC_IRQ_STATUS_RST;
    end else begin
      irq_status <= (irq_status & ~irq_clr) | irq_event;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_status & irq_mask);
    end
  end

  // ----------------------------------------------------------------
  // Avalon-MM slave, one wait state
  // ----------------------------------------------------------------
  logic bus_req;
  logic bus_take;
  logic wr_lane0;
  logic [31:0] rd_value;

  assign bus_req = avs_read_i || avs_write_i;
  assign bus_take = bus_req && !avs_waitrequest_o;
  assign wr_lane0 = bus_take && avs_write_i && avs_byteenable_i[0];
  assign irq_clr = (wr_lane0 && avs_address_i == FRC_REG_IRQ_STATUS) ?
                   avs_writedata_i[FRC_IRQ_W-1:0] : '0;

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      avs_waitrequest_o <= 1'b1;
    end else begin
      avs_waitrequest_o <= !(bus_req && avs_waitrequest_o);
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      irq_mask <= FRC_IRQ_MASK_RST;
    end else if (wr_lane0 && avs_address_i == FRC_REG_IRQ_MASK) begin
      irq_mask <= avs_writedata_i[FRC_IRQ_W-1:0];
    end
  end

  // Soft partial reset is a one-cycle pulse; settings are kept
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      soft_prs <= 1'b0;
    end else begin
      soft_prs <= wr_lane0 && avs_address_i == FRC_REG_CTRL &&
                  avs_writedata_i[FRC_CTRL_SOFT_PRS];
    end
  end

  always_comb begin
    rd_value = 32'h0000_0000;
    case (avs_address_i)
      FRC_REG_CONFIG: rd_value = {19'h00000, cfg};
      FRC_REG_STATUS: begin
        rd_value[FRC_STAT_COUNT_LSB +: FRC_CW] = count;
        rd_value[4:0] = {mark_valid, fifo_full, fifo_empty, almost_full_flag_o,
                         almost_empty_flag_o};
      end
      FRC_REG_OFFSETS: begin
        rd_value[FRC_OFS_FULL_LSB +: FRC_CW] = ofs.full_ofs;
        rd_value[FRC_CW-1:0] = ofs.empty_ofs;
      end
      FRC_REG_IRQ_STATUS: rd_value[FRC_IRQ_W-1:0] = irq_status;
      FRC_REG_IRQ_MASK: rd_value[FRC_IRQ_W-1:0] = irq_mask;
      default: rd_value = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      avs_readdata_o <= 32'h0000_0000;
    end else if (avs_read_i && avs_waitrequest_o) begin
      avs_readdata_o <= rd_value;
    end
  end

endmodule : frc_top

// *** rtl/frc_pkg.sv ***
package frc_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int FRC_ADDR_W = 6;
  localparam int FRC_DEPTH = 64;
  localparam int FRC_DW = 18;
  localparam int FRC_CW = 7;
  localparam logic [FRC_CW-1:0] FRC_DEPTH_CNT = 7'h40;
  localparam logic [FRC_DW-1:0] FRC_MASK_WIDE = 18'h3ffff;
  localparam logic [FRC_DW-1:0] FRC_MASK_NARROW = 18'h001ff;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [4:0] FRC_REG_CONFIG = 5'h00;
  localparam logic [4:0] FRC_REG_STATUS = 5'h04;
  localparam logic [4:0] FRC_REG_OFFSETS = 5'h08;
  localparam logic [4:0] FRC_REG_IRQ_STATUS = 5'h0c;
  localparam logic [4:0] FRC_REG_IRQ_MASK = 5'h10;
  localparam logic [4:0] FRC_REG_CTRL = 5'h14;

  // Field positions
  localparam int FRC_OFS_FULL_LSB = 16;
  localparam int FRC_STAT_COUNT_LSB = 8;
  localparam int FRC_CTRL_SOFT_PRS = 0;

  // Interrupt bits
  localparam int FRC_IRQ_W = 4;
  localparam int FRC_IRQ_AE_RISE = 0;
  localparam int FRC_IRQ_AF_FALL = 1;
  localparam int FRC_IRQ_OVERFLOW = 2;
  localparam int FRC_IRQ_UNDERFLOW = 3;

  // Reset values
  localparam logic [FRC_IRQ_W-1:0] FRC_IRQ_MASK_RST = 4'h0;
  localparam logic [FRC_IRQ_W-1:0] FRC_IRQ_STATUS_RST = 4'h0;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic fall_through_mode;
    logic write_width_select;
    logic read_width_select;
    logic async_write_sel;
    logic async_read_sel;
    logic byte_order_sel;
    logic zero_latency_sel;
    logic parity_sel;
    logic flag_timing_select;
    logic default_offset_sel_hi;
    logic default_offset_sel_lo;
  } frc_strap_t;

  typedef struct packed {
    logic fall_through;
    logic write_narrow;
    logic read_narrow;
    logic async_write;
    logic async_read;
    logic byte_order;
    logic zero_latency;
    logic parity;
    logic flag_sync;
    logic serial_prog;
    logic [2:0] ofs_idx;
  } frc_cfg_t;

  typedef struct packed {
    logic [FRC_CW-1:0] full_ofs;
    logic [FRC_CW-1:0] empty_ofs;
  } frc_ofs_t;

  typedef enum logic {
    FRC_OFS_EMPTY = 1'b0,
    FRC_OFS_FULL = 1'b1
  } frc_ofs_sel_t;

  localparam frc_cfg_t FRC_CFG_RST = '0;

  // Default offset pairs {full, empty}, indexed by {strobe, sel_hi, sel_lo}
  localparam frc_ofs_t FRC_DEF_OFS [8] = '{
    '{7'h07, 7'h07}, '{7'h0f, 7'h0f}, '{7'h1f, 7'h1f}, '{7'h03, 7'h03},
    '{7'h01, 7'h01}, '{7'h10, 7'h10}, '{7'h20, 7'h20}, '{7'h30, 7'h30}
  };

endpackage : frc_pkg

// *** verif/frc_properties.sv ***
`timescale 1ns/1ns
module frc_props
  import frc_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic master_reset_n_i,
  input wire logic output_enable_n_i,
  input wire logic [4:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [FRC_DW-1:0] q_o,
  input wire logic q_oe_n_o,
  input wire logic almost_empty_flag_o,
  input wire logic almost_full_flag_o,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic irq_o
);
  // ----------------
  // Port checks
  // ----------------
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  a_reset_values: assert property (
    disable iff (1'b0) rst_i |=> q_o == '0 && q_oe_n_o && !irq_o && avs_waitrequest_o
      && !almost_empty_flag_o && almost_full_flag_o)
    else $error("outputs wrong after reset");
  a_mrs_clears_q: assert property (!master_reset_n_i [*4] |=> q_o == '0)
    else $error("q not cleared by master reset");
  // Sync and output flop: three edges of latency
  a_oe_off: assert property (output_enable_n_i [*4] |-> q_oe_n_o)
    else $error("q still driven");
  a_oe_on: assert property (!output_enable_n_i [*4] |-> !q_oe_n_o)
    else $error("q not driven");
  a_bus_wait: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
    |=> !avs_waitrequest_o)
    else $error("bus answer late");
  a_bus_pulse: assert property ($fell(avs_waitrequest_o) |=> avs_waitrequest_o)
    else $error("waitrequest low too long");
  a_unmapped_zero: assert property (avs_read_i && avs_waitrequest_o
    && avs_address_i >= FRC_REG_CTRL |=> avs_readdata_o == '0)
    else $error("unmapped read not zero");
  a_irq_masked: assert property (avs_write_i && !avs_waitrequest_o
    && avs_address_i == FRC_REG_IRQ_MASK && avs_writedata_i[3:0] == 4'h0 |=> ##1 !irq_o)
    else $error("irq with all masked");
endmodule : frc_props

// *** verif/frc_host.sv ***
`timescale 1ns/1ns
module frc_host
  import frc_pkg::*;
(
  input wire logic mclk_i,
  output logic wr_en_o,
  output logic rd_en_o,
  output logic mark_o,
  output logic rt_o,
  output logic strobe_n_o,
  output logic [FRC_DW-1:0] wr_data_o
);
  // ----------------
  // Host port model
  // ----------------
  initial begin
    {wr_en_o, rd_en_o, mark_o, rt_o} = 4'h0;
    strobe_n_o = 1'b1;
    wr_data_o = '0;
  end

  // Code bits: write, read, mark, retransmit; one cycle each
  task automatic op(input logic [3:0] c, input logic [FRC_DW-1:0] d);
    @(posedge mclk_i);
    {wr_en_o, rd_en_o, mark_o, rt_o} <= c;
    wr_data_o <= d;
    @(posedge mclk_i);
    {wr_en_o, rd_en_o, mark_o, rt_o} <= 4'h0;
    // Idle bus shows junk so stale data never passes
    wr_data_o <= ~d;
  endtask : op

  task automatic strobe(input logic v);
    strobe_n_o <= v;
  endtask : strobe
endmodule : frc_host

// *** verif/tb.sv ***
`timescale 1ns/1ns
module tb
  import frc_pkg::*;
;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  frc_strap_t strap_i = '0;
  logic master_reset_n_i = 1'b1;
  logic partial_reset_n_i = 1'b1;
  logic output_enable_n_i = 1'b0;
  logic serial_offset_clk_i = 1'b0;
  logic serial_offset_enable_n_i = 1'b1;
  logic offset_access_strobe_n_i, mark_i, retransmit_i, wr_en_i, rd_en_i;
  logic [FRC_DW-1:0] wr_data_i, q_o;
  logic q_oe_n_o, almost_empty_flag_o, almost_full_flag_o, avs_waitrequest_o, irq_o;
  logic [4:0] avs_address_i = '0;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = '0;
  logic [3:0] avs_byteenable_i = 4'hf;
  logic [31:0] avs_readdata_o;
  int bad_count = 0;
  int compares = 0;

  frc_top uut (.*);
  frc_host host (
    .mclk_i, .wr_en_o(wr_en_i), .rd_en_o(rd_en_i), .mark_o(mark_i), .rt_o(retransmit_i),
    .strobe_n_o(offset_access_strobe_n_i), .wr_data_o(wr_data_i)
  );

  always #25 mclk_i = ~mclk_i;

  // ----------------
  // Helpers
  // ----------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
      bad_count++;
    end
  endtask : chk

  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    int n;
    n = 0;
    @(posedge mclk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= w;
    avs_read_i <= ~w;
    // Only the watchdog ends a wait; the slave adds exactly one wait state
    do begin
      @(posedge mclk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0);
    r = avs_readdata_o;
    chk(32'(n), 32'h2);
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask : bus

  task automatic pop(input logic [FRC_DW-1:0] e);
    host.op(4'h4, '0);
    @(posedge mclk_i);
    chk(32'(q_o), 32'(e));
  endtask : pop

  // ----------------
  // Scenarios
  // ----------------
  task automatic master_reset(input frc_strap_t s, input logic ld, input logic [7:0] ecfg);
    logic [31:0] r;
    frc_ofs_t o;
    o = FRC_DEF_OFS[ecfg[2:0]];
    strap_i <= s;
    host.strobe(ld);
    master_reset_n_i <= 1'b0;
    output_enable_n_i <= 1'b1;
    repeat (4) @(posedge mclk_i);
    chk(32'(q_oe_n_o), 32'h1);
    output_enable_n_i <= 1'b0;
    repeat (4) @(posedge mclk_i);
    chk(32'(q_oe_n_o), 32'h0);
    master_reset_n_i <= 1'b1;
    repeat (4) @(posedge mclk_i);
    chk(32'(q_o), 32'h0);
    // Straps move after reset; latched setup must not
    strap_i <= ~s;
    host.strobe(1'b1);
    bus(1'b0, FRC_REG_CONFIG, '0, r);
    chk({r[12:10], r[4:0]}, 32'(ecfg));
    bus(1'b0, FRC_REG_OFFSETS, '0, r);
    chk(r, {9'h0, o.full_ofs, 9'h0, o.empty_ofs});
    bus(1'b0, FRC_REG_STATUS, '0, r);
    chk(32'(r[14:8]), 32'h0);
    $display("master reset done");
  endtask : master_reset

  task automatic t_serial;
    logic [31:0] r;
    logic [13:0] v;
    v = 14'h0289;
    serial_offset_enable_n_i <= 1'b0;
    for (int i = 13; i >= 0; i--) begin
      strap_i.fall_through_mode <= v[i];
      repeat (4) @(posedge mclk_i);
      serial_offset_clk_i <= 1'b1;
      repeat (4) @(posedge mclk_i);
      serial_offset_clk_i <= 1'b0;
    end
    repeat (4) @(posedge mclk_i);
    serial_offset_enable_n_i <= 1'b1;
    bus(1'b0, FRC_REG_OFFSETS, '0, r);
    chk(r, 32'h0005_0009);
    $display("serial done");
  endtask : t_serial

  task automatic t_offsets;
    logic [31:0] r;
    host.strobe(1'b0);
    host.op(4'h8, 18'h00002);
    host.op(4'h8, 18'h00003);
    bus(1'b0, FRC_REG_OFFSETS, '0, r);
    chk(r, 32'h0003_0002);
    pop(18'h00002);
    pop(18'h00003);
    host.strobe(1'b1);
    $display("offsets done");
  endtask : t_offsets

  // Offsets n=2, m=3; the last write hits a full FIFO
  task automatic t_flags;
    logic [31:0] r;
    for (int i = 0; i < 65; i++) begin
      host.op(4'h8, 18'(i));
      repeat (3) @(posedge mclk_i);
      if (i == 0) chk(32'(almost_empty_flag_o), 32'h0);
      if (i == 1) chk(32'(almost_empty_flag_o), 32'h1);
      if (i == 59) chk(32'(almost_full_flag_o), 32'h1);
      if (i == 60) chk(32'(almost_full_flag_o), 32'h0);
    end
    bus(1'b0, FRC_REG_IRQ_STATUS, '0, r);
    chk(32'(r[3:0]), 32'h7);
    chk(32'(irq_o), 32'h0);
    bus(1'b1, FRC_REG_IRQ_MASK, 32'h4, r);
    repeat (2) @(posedge mclk_i);
    chk(32'(irq_o), 32'h1);
    bus(1'b1, FRC_REG_IRQ_STATUS, 32'h4, r);
    repeat (2) @(posedge mclk_i);
    chk(32'(irq_o), 32'h0);
    bus(1'b0, FRC_REG_IRQ_STATUS, '0, r);
    chk(32'(r[3:0]), 32'h3);
    bus(1'b0, FRC_REG_IRQ_MASK, '0, r);
    chk(r, 32'h4);
    bus(1'b0, 5'h18, '0, r);
    chk(r, 32'h0);
    bus(1'b1, FRC_REG_IRQ_MASK, 32'h0, r);
    $display("flags done");
  endtask : t_flags

  task automatic t_mark;
    pop(18'h00000);
    pop(18'h00001);
    host.op(4'h2, '0);
    pop(18'h00002);
    pop(18'h00003);
    host.op(4'h1, '0);
    pop(18'h00002);
    $display("mark done");
  endtask : t_mark

  // Partial resets empty the FIFO but keep offsets; an empty read underflows
  task automatic t_prs;
    logic [31:0] r;
    partial_reset_n_i <= 1'b0;
    repeat (4) @(posedge mclk_i);
    partial_reset_n_i <= 1'b1;
    repeat (4) @(posedge mclk_i);
    chk(32'(q_o), 32'h0);
    bus(1'b0, FRC_REG_OFFSETS, '0, r);
    chk(r, 32'h0003_0002);
    host.op(4'h4, '0);
    bus(1'b0, FRC_REG_IRQ_STATUS, '0, r);
    chk(32'(r[3:0]), 32'hb);
    host.op(4'h8, 18'h00155);
    bus(1'b0, FRC_REG_STATUS, '0, r);
    chk(32'(r[14:8]), 32'h1);
    bus(1'b1, FRC_REG_CTRL, 32'h1, r);
    bus(1'b0, FRC_REG_STATUS, '0, r);
    chk(32'(r[14:8]), 32'h0);
    $display("partial reset done");
  endtask : t_prs

  task automatic results;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : results

  initial begin
    repeat (6) @(posedge mclk_i);
    rst_i <= 1'b0;
    // Strobe pin low at master reset selects serial offset loading
    master_reset(frc_strap_t'(11'h202), 1'b0, 8'h4a);
    t_serial;
    master_reset(frc_strap_t'(11'h107), 1'b1, 8'h37);
    t_offsets;
    t_flags;
    t_mark;
    t_prs;
    master_reset(frc_strap_t'(11'h107), 1'b1, 8'h37);
    results;
  end

  // Whole run is near 600 cycles; the watchdog fires after 40000
  initial begin
    #2000000;
    bad_count++;
    results;
  end
endmodule : tb

bind frc_top frc_props u_props (
  .mclk_i, .rst_i, .master_reset_n_i, .output_enable_n_i, .avs_address_i, .avs_read_i,
  .avs_write_i, .avs_writedata_i, .q_o, .q_oe_n_o, .almost_empty_flag_o,
  .almost_full_flag_o, .avs_readdata_o, .avs_waitrequest_o, .irq_o
);
